// *** common/frsus_pkg.sv ***
// frsus_pkg: constants, types and states for the flash rewrite status/suspend block
// assumes a single 40 MHz clock domain and the plain register port of frsus_top
package frsus_pkg;

   // -----------------------------------------------------------------
   // register map (word index on the plain port)
   // -----------------------------------------------------------------
   localparam logic [3:0] FRSUS_A_CMD    = 4'h0; // command byte write
   localparam logic [3:0] FRSUS_A_STATUS = 4'h1; // flash_status_reg
   localparam logic [3:0] FRSUS_A_CTRL_A = 4'h2; // flash_ctrl_reg_a
   localparam logic [3:0] FRSUS_A_CTRL_B = 4'h3; // flash_ctrl_reg_b
   localparam logic [3:0] FRSUS_A_CTRL_C = 4'h4; // flash_ctrl_reg_c

   // field positions
   localparam int FRSUS_B_REWRITE = 1; // ctrl_a: cpu_rewrite_enable
   localparam int FRSUS_B_STOP    = 3; // ctrl_a: flash_stop
   localparam int FRSUS_B_SUS_EN  = 0; // ctrl_c: suspend_enable
   localparam int FRSUS_B_SUS_REQ = 1; // ctrl_c: suspend_request
   localparam int FRSUS_B_IRQ_SUS = 2; // ctrl_c: irq_suspend_allow
   localparam int FRSUS_B_ERR_LO  = 4; // status: err_status_low
   localparam int FRSUS_B_ERR_HI  = 5; // status: err_status_high
   localparam int FRSUS_B_READY   = 7; // status: ready
   localparam int FRSUS_B_ESUS    = 6; // status: erase suspended
   localparam int FRSUS_B_PSUS    = 2; // status: program suspended

   localparam logic [7:0] FRSUS_RST_CTRL = 8'h00;

   // command codes
   localparam logic [7:0] FRSUS_C_READ    = 8'hFF; // cancel / read array
   localparam logic [7:0] FRSUS_C_CONFIRM = 8'hD0;
   localparam logic [7:0] FRSUS_C_PROG    = 8'h40;
   localparam logic [7:0] FRSUS_C_ERASE   = 8'h20;
   localparam logic [7:0] FRSUS_C_LOCKPRG = 8'h77;
   localparam logic [7:0] FRSUS_C_LOCKRD  = 8'h71;
   localparam logic [7:0] FRSUS_C_BLANK   = 8'h25;
   localparam logic [7:0] FRSUS_C_CLRST   = 8'h50;
   localparam logic [7:0] FRSUS_ERASED    = 8'hFF;

   // error patterns {high, low}
   localparam logic [1:0] FRSUS_E_NONE = 2'h0;
   localparam logic [1:0] FRSUS_E_PROG = 2'h1;
   localparam logic [1:0] FRSUS_E_ERAS = 2'h2;
   localparam logic [1:0] FRSUS_E_SEQ  = 2'h3;

   // timing
   localparam int FRSUS_CLK_MHZ      = 40;
   localparam int FRSUS_SUS_LAT_US   = 5;   // suspend_latency
   localparam int FRSUS_RESTART_US   = 10;  // restart wait after abort
   localparam int FRSUS_SUS_CYC      = FRSUS_SUS_LAT_US * FRSUS_CLK_MHZ;
   localparam int FRSUS_RESTART_CYC  = FRSUS_RESTART_US * FRSUS_CLK_MHZ;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      FRSUS_IDLE    = 3'b000, // read array / ready
      FRSUS_SECOND  = 3'b001, // waiting for second byte
      FRSUS_RUN     = 3'b010, // auto operation in progress
      FRSUS_PAUSING = 3'b011, // suspend latency running
      FRSUS_SUSP    = 3'b100, // operation suspended
      FRSUS_ABORT   = 3'b101  // flash reset and restart wait
   } frsus_state_t;

   typedef enum logic [2:0] {
      FRSUS_OP_NONE  = 3'b000,
      FRSUS_OP_PROG  = 3'b001,
      FRSUS_OP_ERASE = 3'b010,
      FRSUS_OP_LOCKP = 3'b011,
      FRSUS_OP_LOCKR = 3'b100,
      FRSUS_OP_BLANK = 3'b101
   } frsus_op_t;

   // result from the flash array macro
   typedef struct packed {
      logic       done;    // one-cycle completion pulse
      logic       fail;    // auto operation not normal
      logic       lock_bit; // lock bit after lock program
      logic [7:0] data;    // byte seen by blank check
   } frsus_array_t;

   // interrupt acknowledge from the core
   typedef struct packed {
      logic maskable;   // maskable acknowledged
      logic fatal;      // watchdog / osc stop / voltage monitor
   } frsus_irq_t;

endpackage : frsus_pkg

// *** hw/frsus_top.sv ***
// frsus_top: command check, error status and irq suspend/abort for flash rewrite
// assumes the core and array macro run on mclk; irq acks are same-domain pulses
`timescale 1ns/100ps
`default_nettype none

module frsus_top
   import frsus_pkg::*;
#(
   parameter int SUS_CYC     = FRSUS_SUS_CYC,
   parameter int RESTART_CYC = FRSUS_RESTART_CYC
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [3:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [7:0]        reg_rdata,
   input  wire logic [1:0]   cmd_block,     // block targeted by command
   input  wire frsus_irq_t   irq_ack,
   input  wire frsus_array_t array_res,
   output logic              array_start,   // start auto operation
   output frsus_op_t         array_op,
   output logic              array_hold,    // pause auto operation
   output logic              array_reset,   // forced flash reset
   output logic              irq_service_ok, // core may enter handler
   output logic [1:0]        busy_block,    // block not readable/writable
   output logic              block_locked_out, // busy block is fenced
   output logic              wdt_gate       // watchdog clock gate, never set
);

   // the shared down-counter is only 16 bits wide
   if (SUS_CYC < 1 || SUS_CYC > 65535 || RESTART_CYC < 1
       || RESTART_CYC > 65535) begin : g_bad_cycles
      $error("frsus_top: cycle counts out of range");
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   frsus_state_t state_q, state_d;
   frsus_op_t    op_q, op_d, first_q;
   logic [1:0]   err_q;
   logic [15:0]  cnt_q;
   logic [7:0]   ctrl_a_q, ctrl_b_q, ctrl_c_q;
   logic         irq_pend_q;
   logic [7:0]   rdata_q;
   logic [1:0]   blk_q;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire cmd_wr    = reg_wr && (reg_addr == FRSUS_A_CMD);
   wire wr_a      = reg_wr && (reg_addr == FRSUS_A_CTRL_A);
   wire wr_b      = reg_wr && (reg_addr == FRSUS_A_CTRL_B);
   wire wr_c      = reg_wr && (reg_addr == FRSUS_A_CTRL_C);
   wire sus_en    = ctrl_c_q[FRSUS_B_SUS_EN];
   wire irq_sus   = ctrl_c_q[FRSUS_B_IRQ_SUS];
   wire sus_req   = ctrl_c_q[FRSUS_B_SUS_REQ];
   wire active    = (state_q == FRSUS_RUN) || (state_q == FRSUS_PAUSING)
                    || (state_q == FRSUS_SUSP)
                    || (state_q == FRSUS_SECOND && op_q != FRSUS_OP_NONE);
   wire susp_any  = (state_q == FRSUS_SUSP);
   wire esus      = susp_any && (op_q == FRSUS_OP_ERASE);
   wire psus      = susp_any && (op_q != FRSUS_OP_ERASE);
   wire fatal_hit = irq_ack.fatal && active;
   // fatal with rewrite enabled and flash stopped also clears registers
   wire fatal_stop = irq_ack.fatal && ctrl_a_q[FRSUS_B_REWRITE]
                     && ctrl_a_q[FRSUS_B_STOP];
   wire ctrl_clear = fatal_hit || fatal_stop;
   wire auto_sus  = irq_ack.maskable && sus_en && irq_sus
                    && (state_q == FRSUS_RUN);
   wire resume_wr = wr_c && !reg_wdata[FRSUS_B_SUS_REQ] && susp_any;
   wire cnt_zero  = (cnt_q == 16'h0000);

   // first-byte classification
   function automatic frsus_op_t first_op(input logic [7:0] b);
      case (b)
         FRSUS_C_PROG:    first_op = FRSUS_OP_PROG;
         FRSUS_C_ERASE:   first_op = FRSUS_OP_ERASE;
         FRSUS_C_LOCKPRG: first_op = FRSUS_OP_LOCKP;
         FRSUS_C_LOCKRD:  first_op = FRSUS_OP_LOCKR;
         FRSUS_C_BLANK:   first_op = FRSUS_OP_BLANK;
         default:         first_op = FRSUS_OP_NONE;
      endcase
   endfunction

   // command legality during suspend
   function automatic logic sus_reject(input frsus_op_t o, input logic e, input logic p);
      sus_reject = (e && (o == FRSUS_OP_ERASE || o == FRSUS_OP_BLANK))
                || (p && (o == FRSUS_OP_PROG || o == FRSUS_OP_LOCKP
                          || o == FRSUS_OP_ERASE || o == FRSUS_OP_BLANK));
   endfunction

   wire frsus_op_t fop   = first_op(reg_wdata);
   wire known_first      = (fop != FRSUS_OP_NONE);
   wire is_cancel        = (reg_wdata == FRSUS_C_READ);
   wire is_confirm       = (reg_wdata == FRSUS_C_CONFIRM);
   wire is_clrst         = (reg_wdata == FRSUS_C_CLRST);
   // program takes its data byte as second write, others need confirm
   wire second_ok        = (first_q == FRSUS_OP_PROG) || is_confirm;
   wire idle_like        = (state_q == FRSUS_IDLE) || susp_any;
   wire first_take       = cmd_wr && idle_like && known_first
                           && !sus_reject(fop, esus, psus);
   wire first_bad        = cmd_wr && idle_like && !known_first && !is_cancel
                           && !is_clrst;
   wire first_rej        = cmd_wr && idle_like && known_first
                           && sus_reject(fop, esus, psus);
   wire second_wr        = cmd_wr && (state_q == FRSUS_SECOND);
   wire second_cancel    = second_wr && is_cancel && (first_q != FRSUS_OP_PROG);
   wire launch           = second_wr && second_ok && !second_cancel;
   wire second_bad       = second_wr && !second_ok && !is_cancel;

   // result encoding on completion
   function automatic logic [1:0] result_err(input frsus_op_t o, input frsus_array_t r);
      case (o)
         FRSUS_OP_ERASE: result_err = r.fail ? FRSUS_E_ERAS : FRSUS_E_NONE;
         FRSUS_OP_BLANK: result_err = (r.data != FRSUS_ERASED) ? FRSUS_E_ERAS
                                                             : FRSUS_E_NONE;
         FRSUS_OP_PROG:  result_err = r.fail ? FRSUS_E_PROG : FRSUS_E_NONE;
         FRSUS_OP_LOCKP: result_err = r.lock_bit ? FRSUS_E_PROG : FRSUS_E_NONE;
         default:        result_err = FRSUS_E_NONE;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // sequencer next state
   // -----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      case (state_q)
         FRSUS_IDLE: begin
            if (first_take)
               state_d = FRSUS_SECOND;
         end
         FRSUS_SECOND: begin
            if (fatal_hit)
               state_d = FRSUS_ABORT;
            else if (second_cancel || second_bad)
               state_d = (op_q != FRSUS_OP_NONE) ? FRSUS_SUSP : FRSUS_IDLE;
            else if (launch && op_q == FRSUS_OP_NONE) begin
               state_d = FRSUS_RUN;
               op_d    = first_q;
            end else if (launch)
               state_d = FRSUS_SUSP; // nested op on other block, modelled as accepted
         end
         FRSUS_RUN: begin
            if (fatal_hit)
               state_d = FRSUS_ABORT;
            else if (auto_sus || (wr_c && reg_wdata[FRSUS_B_SUS_REQ] && sus_en))
               state_d = FRSUS_PAUSING;
            else if (array_res.done) begin
               state_d = FRSUS_IDLE;
               op_d    = FRSUS_OP_NONE;
            end
         end
         FRSUS_PAUSING: begin
            if (fatal_hit)
               state_d = FRSUS_ABORT;
            else if (cnt_zero)
               state_d = FRSUS_SUSP;
         end
         FRSUS_SUSP: begin
            if (fatal_hit)
               state_d = FRSUS_ABORT;
            else if (resume_wr)
               state_d = FRSUS_RUN;
            else if (first_take)
               state_d = FRSUS_SECOND;
         end
         FRSUS_ABORT: begin
            if (cnt_zero) begin
               state_d = FRSUS_IDLE;
               op_d    = FRSUS_OP_NONE;
            end
         end
         default: begin
            state_d = FRSUS_IDLE;
            op_d    = FRSUS_OP_NONE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // state, counter and first byte
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= FRSUS_IDLE;
         op_q    <= FRSUS_OP_NONE;
         first_q <= FRSUS_OP_NONE;
         blk_q   <= 2'h0;
      end else begin
         state_q <= state_d;
         op_q    <= state_d == FRSUS_SECOND && susp_any ? op_q : op_d;
         if (first_take)
            first_q <= fop;
         if (launch && op_q == FRSUS_OP_NONE)
            blk_q <= cmd_block;
      end
   end

   // one down-counter serves both the suspend latency and the restart wait
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         cnt_q <= 16'h0000;
      else if (state_q != FRSUS_ABORT && state_d == FRSUS_ABORT)
         cnt_q <= 16'(RESTART_CYC - 1);
      else if (state_q == FRSUS_RUN && state_d == FRSUS_PAUSING)
         cnt_q <= 16'(SUS_CYC - 1);
      else if (!cnt_zero)
         cnt_q <= cnt_q - 16'h0001;
   end

   // -----------------------------------------------------------------
   // error status: read-only, changes on command events and on array completion
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         err_q <= FRSUS_E_NONE;
      else if (first_bad || first_rej || second_bad)
         err_q <= FRSUS_E_SEQ;
      else if (state_q == FRSUS_RUN && array_res.done && !fatal_hit)
         err_q <= result_err(op_q, array_res);
      else if (first_take || (cmd_wr && is_clrst && idle_like))
         err_q <= FRSUS_E_NONE;
   end

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_a_q <= FRSUS_RST_CTRL;
         ctrl_b_q <= FRSUS_RST_CTRL;
         ctrl_c_q <= FRSUS_RST_CTRL;
      end else if (ctrl_clear) begin
         ctrl_a_q <= FRSUS_RST_CTRL;
         ctrl_b_q <= FRSUS_RST_CTRL;
         ctrl_c_q <= FRSUS_RST_CTRL;
      end else begin
         if (wr_a)
            ctrl_a_q <= reg_wdata;
         if (wr_b)
            ctrl_b_q <= reg_wdata;
         if (auto_sus)
            ctrl_c_q[FRSUS_B_SUS_REQ] <= 1'b1;
         else if (wr_c)
            ctrl_c_q <= reg_wdata;
      end
   end

   // maskable irq held off while the array finishes or pauses
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         irq_pend_q <= 1'b0;
      else if (irq_ack.maskable || irq_ack.fatal)
         irq_pend_q <= 1'b1;
      else if (irq_service_ok)
         irq_pend_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // read data, one cycle after the strobe
   // -----------------------------------------------------------------
   wire [7:0] status_w = {(state_q == FRSUS_IDLE), esus, err_q, 1'b0, psus, 2'h0};
   wire [7:0] rd_mux = (reg_addr == FRSUS_A_STATUS) ? status_w :
                       (reg_addr == FRSUS_A_CTRL_A) ? ctrl_a_q :
                       (reg_addr == FRSUS_A_CTRL_B) ? ctrl_b_q :
                       (reg_addr == FRSUS_A_CTRL_C) ? ctrl_c_q : 8'h00;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         rdata_q <= 8'h00;
      else
         rdata_q <= reg_rd ? rd_mux : 8'h00;
   end

   // -----------------------------------------------------------------
   // outputs toward the array and the core
   // -----------------------------------------------------------------
   assign reg_rdata        = rdata_q;
   assign array_start      = (state_q != FRSUS_RUN) && (state_d == FRSUS_RUN);
   assign array_op         = op_d;
   assign array_hold       = susp_any || (state_q == FRSUS_SECOND && op_q != FRSUS_OP_NONE);
   assign array_reset      = (state_q == FRSUS_ABORT);
   // no service while running or pausing or restarting
   assign irq_service_ok   = irq_pend_q && !(state_q == FRSUS_RUN || state_q == FRSUS_PAUSING
                                             || state_q == FRSUS_ABORT);
   assign busy_block       = blk_q;
   assign block_locked_out = active;
   assign wdt_gate         = 1'b0;

endmodule // frsus_top

`default_nettype wire

// *** test/frsus_array_model.sv ***
// frsus_array_model: behavioural flash array answering the sequencer
// assumes start, hold and reset from frsus_top on the same mclk
`timescale 1ns/100ps
`default_nettype none
module frsus_array_model
   import frsus_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         array_start,
   input  wire logic         array_hold,
   input  wire logic         array_reset,
   input  wire logic [7:0]   dur,
   input  wire logic         fail_mode,
   input  wire logic         lock_mode,
   input  wire logic [7:0]   blank_byte,
   output frsus_array_t      array_res
);
   logic [7:0] cnt_q;
   logic       done_q;
   // countdown frozen while held; a restart keeps the remaining count
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= 8'h00;
         done_q <= 1'b0;
      end else if (array_reset) begin
         cnt_q  <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= cnt_q == 8'h01 && !array_hold;
         if (array_start && cnt_q == 8'h00) cnt_q <= dur;
         else if (cnt_q != 8'h00 && !array_hold) cnt_q <= cnt_q - 8'h01;
      end
   end
   // outside the done pulse the result lines show inverted junk, never stale values
   assign array_res.done     = done_q;
   assign array_res.fail     = done_q ? fail_mode : !fail_mode;
   assign array_res.lock_bit = done_q ? lock_mode : !lock_mode;
   assign array_res.data     = done_q ? blank_byte : ~blank_byte;
endmodule // frsus_array_model
`default_nettype wire

// *** test/frsus_top_props.sv ***
// frsus_top_props: port-level checks for the flash status and suspend block
// assumes it is bound onto frsus_top and sees only mclk and its ports
`timescale 1ns/100ps
`default_nettype none
module frsus_top_props
   import frsus_pkg::*;
#(
   parameter int SUS_CYC     = FRSUS_SUS_CYC,
   parameter int RESTART_CYC = FRSUS_RESTART_CYC
) (
   input wire logic         mclk,
   input wire logic         rstn,
   input wire logic [3:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [7:0]   reg_rdata,
   input wire frsus_irq_t   irq_ack,
   input wire frsus_array_t array_res,
   input wire logic         array_start,
   input wire logic         array_hold,
   input wire logic         array_reset,
   input wire logic         irq_service_ok,
   input wire logic         wdt_gate
);
   // ----------------------------------------
   // helper counter and properties
   // ----------------------------------------
   logic [15:0] rst_cnt_q;
   // length of the current flash reset window, so the wait is checked exactly
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) rst_cnt_q <= 16'h0000;
      else rst_cnt_q <= array_reset ? rst_cnt_q + 16'h0001 : 16'h0000;
   end
   logic busy_q;
   // set by a start, dropped on done or flash reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) busy_q <= 1'b0;
      else if (array_res.done || array_reset) busy_q <= 1'b0;
      else if (array_start) busy_q <= 1'b1;
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rstn);
   wdt_gate_low_a: assert property (wdt_gate == 1'b0)
      else $error("watchdog gate raised");
   hold_no_start_a: assert property (array_hold &&
      !(reg_wr && reg_addr == FRSUS_A_CTRL_C) |-> !array_start)
      else $error("start while held");
   abort_no_service_a: assert property (array_reset |-> !irq_service_ok && !array_start)
      else $error("service or start during flash reset");
   fatal_abort_a: assert property (irq_ack.fatal && busy_q |=> array_reset)
      else $error("fatal ack did not reset flash");
   abort_len_a: assert property ($fell(array_reset) |-> rst_cnt_q == 16'(RESTART_CYC))
      else $error("restart wait length wrong");
   start_pulse_a: assert property (array_start |=> !array_start)
      else $error("start longer than one cycle");
   abort_hold_clear_a: assert property (array_reset |-> !array_hold)
      else $error("hold kept during flash reset");
   rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   resume_start_a: assert property (reg_wr && reg_addr == FRSUS_A_CTRL_C &&
      !reg_wdata[FRSUS_B_SUS_REQ] && array_hold |-> ##[0:1] array_start)
      else $error("no restart on suspend clear");
endmodule // frsus_top_props
bind frsus_top frsus_top_props #(.SUS_CYC(SUS_CYC), .RESTART_CYC(RESTART_CYC)) props_i (
   .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
   .array_start(array_start), .array_hold(array_hold), .array_reset(array_reset),
   .irq_service_ok(irq_service_ok), .wdt_gate(wdt_gate), .array_res(array_res));
`default_nettype wire

// *** test/frsus_top_test.sv ***
// frsus_top_test: directed scenarios for command status, suspend and abort
// assumes frsus_top and frsus_array_model on a 40 MHz mclk
`timescale 1ns/100ps
`default_nettype none
module frsus_top_test
   import frsus_pkg::*;
;
   logic         mclk, rstn, reg_wr, reg_rd, fail_mode, lock_mode;
   logic         array_start, array_hold, array_reset, irq_service_ok, wdt_gate;
   logic         block_locked_out;
   logic [1:0]   busy_block;
   logic [3:0]   reg_addr;
   logic [7:0]   reg_wdata, reg_rdata, dur, blank_byte, v;
   frsus_irq_t   irq_ack;
   frsus_array_t array_res;
   int           failures, checks, cyc;
   // ----------------------------------------
   // clock, reset, instances
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   frsus_top #(.SUS_CYC(3), .RESTART_CYC(5)) uut (.mclk(mclk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_block(2'h1), .irq_ack(irq_ack), .array_res(array_res),
      .array_start(array_start), .array_op(), .array_hold(array_hold),
      .array_reset(array_reset), .irq_service_ok(irq_service_ok), .busy_block(busy_block),
      .block_locked_out(block_locked_out), .wdt_gate(wdt_gate));
   frsus_array_model far_i (.mclk(mclk), .rstn(rstn), .array_start(array_start),
      .array_hold(array_hold), .array_reset(array_reset), .dur(dur),
      .fail_mode(fail_mode), .lock_mode(lock_mode), .blank_byte(blank_byte),
      .array_res(array_res));
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic results();
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk) reg_wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic st(input logic [1:0] e);
      rd(FRSUS_A_STATUS);
      check({6'h00, v[FRSUS_B_ERR_HI], v[FRSUS_B_ERR_LO]}, {6'h00, e});
   endtask
   task automatic cmd2(input logic [7:0] c1, input logic [7:0] c2);
      wr(FRSUS_A_CMD, c1);
      wr(FRSUS_A_CMD, c2);
   endtask
   task automatic pulse(input logic fatal);
      @(posedge mclk) irq_ack <= fatal ? 2'b01 : 2'b10;
      @(posedge mclk) irq_ack <= 2'b00;
   endtask
   // bounded poll of the ready flag
   task automatic wait_ready();
      for (int i = 0; i < 100; i++) begin
         rd(FRSUS_A_STATUS);
         if (v[FRSUS_B_READY] === 1'b1) return;
      end
      check(8'h00, 8'h01);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_errors();
      logic [7:0] c [4] = '{FRSUS_C_ERASE, FRSUS_C_LOCKPRG, FRSUS_C_LOCKRD, FRSUS_C_BLANK};
      wr(FRSUS_A_CMD, 8'h00);
      st(FRSUS_E_SEQ);
      wr(FRSUS_A_STATUS, 8'h00);
      st(FRSUS_E_SEQ);
      foreach (c[i]) begin
         wr(FRSUS_A_CMD, FRSUS_C_CLRST);
         cmd2(c[i], 8'h12);
         st(FRSUS_E_SEQ);
         cmd2(c[i], FRSUS_C_READ);
         st(FRSUS_E_NONE);
         check({7'h00, v[FRSUS_B_READY]}, 8'h01);
      end
   endtask
   task automatic run(input logic [7:0] c1, input logic [7:0] c2, input logic f,
                      input logic l, input logic [7:0] b, input logic [1:0] e);
      {fail_mode, lock_mode, blank_byte, dur} <= {f, l, b, 8'h14};
      wr(FRSUS_A_CMD, FRSUS_C_CLRST);
      cmd2(c1, c2);
      wait_ready();
      st(e);
   endtask
   // suspend by maskable ack, refuse illegal commands, then resume
   task automatic t_susp(input logic [7:0] c1, input logic [7:0] c2, input int sb,
                         input int n);
      logic [7:0] bad [4] = '{FRSUS_C_ERASE, FRSUS_C_BLANK, FRSUS_C_PROG, FRSUS_C_LOCKPRG};
      {fail_mode, lock_mode, blank_byte, dur} <= {1'b0, 1'b0, 8'hFF, 8'h3C};
      wr(FRSUS_A_CTRL_C, 8'h05);
      cmd2(c1, c2);
      pulse(1'b0);
      rd(FRSUS_A_CTRL_C);
      check(v & 8'h02, 8'h02);
      repeat (6) @(posedge mclk);
      #1 check({7'h00, array_hold}, 8'h01);
      check({5'h00, block_locked_out, busy_block}, 8'h05);
      rd(FRSUS_A_STATUS);
      check({7'h00, v[sb]}, 8'h01);
      for (int i = 0; i < n; i++) begin
         cmd2(bad[i], FRSUS_C_CONFIRM);
         st(FRSUS_E_SEQ);
      end
      wr(FRSUS_A_CMD, FRSUS_C_CLRST);
      wr(FRSUS_A_CTRL_C, 8'h05);
      wait_ready();
      check({7'h00, v[sb]}, 8'h00);
      st(FRSUS_E_NONE);
   endtask
   task automatic t_nosus();
      wr(FRSUS_A_CTRL_C, 8'h01);
      cmd2(FRSUS_C_ERASE, FRSUS_C_CONFIRM);
      pulse(1'b0);
      #1 check({7'h00, irq_service_ok}, 8'h00);
      rd(FRSUS_A_CTRL_C);
      check(v, 8'h01);
      // service_ok stands a single cycle once the erase is done
      for (int i = 0; i < 200 && irq_service_ok !== 1'b1; i++) @(posedge mclk) #1;
      check({7'h00, irq_service_ok}, 8'h01);
      rd(FRSUS_A_STATUS);
      check({7'h00, v[FRSUS_B_READY]}, 8'h01);
   endtask
   // fatal ack resets the flash when busy and clears all three control registers when busy or with rewrite and stop set
   task automatic t_fatal(input logic busy, input logic [7:0] a);
      wr(FRSUS_A_CTRL_A, a);
      wr(FRSUS_A_CTRL_B, 8'h01);
      wr(FRSUS_A_CTRL_C, 8'h05);
      rd(FRSUS_A_CTRL_B);
      check(v, 8'h01);
      if (busy) cmd2(FRSUS_C_ERASE, FRSUS_C_CONFIRM);
      pulse(1'b1);
      #1 if (busy) check({7'h00, array_reset}, 8'h01);
      repeat (8) @(posedge mclk);
      check({7'h00, array_reset}, 8'h00);
      for (int r = 2; r < 5; r++) begin
         rd(r[3:0]);
         check(v, FRSUS_RST_CTRL);
      end
      if (busy) wr(FRSUS_A_CTRL_A, a);
      if (busy) run(FRSUS_C_ERASE, FRSUS_C_CONFIRM, 1'b0, 1'b0, 8'hFF, FRSUS_E_NONE);
   endtask
   // ----------------------------------------
   // main sequence and timeout
   // ----------------------------------------
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, irq_ack} = '0;
      {fail_mode, lock_mode, blank_byte, dur} = {1'b0, 1'b0, 8'hFF, 8'h14};
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      t_errors();
      run(FRSUS_C_ERASE, FRSUS_C_CONFIRM, 1'b1, 1'b0, 8'hFF, FRSUS_E_ERAS);
      run(FRSUS_C_BLANK, FRSUS_C_CONFIRM, 1'b0, 1'b0, 8'h7F, FRSUS_E_ERAS);
      run(FRSUS_C_PROG, 8'h5A, 1'b1, 1'b0, 8'hFF, FRSUS_E_PROG);
      run(FRSUS_C_LOCKPRG, FRSUS_C_CONFIRM, 1'b0, 1'b1, 8'hFF, FRSUS_E_PROG);
      run(FRSUS_C_ERASE, FRSUS_C_CONFIRM, 1'b0, 1'b0, 8'hFF, FRSUS_E_NONE);
      t_susp(FRSUS_C_ERASE, FRSUS_C_CONFIRM, FRSUS_B_ESUS, 2);
      t_susp(FRSUS_C_PROG, 8'h5A, FRSUS_B_PSUS, 4);
      t_nosus();
      t_fatal(1'b1, 8'h02);
      t_fatal(1'b0, 8'h0A);
      check({7'h00, wdt_gate}, 8'h00);
      results();
   end
   // hang guard well above the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
endmodule // frsus_top_test
`default_nettype wire
